// [hdl/emx_exec_ctrl.sv]
// user-mode executive control with avalon-mm register slave
// How it works
// - bound/relocation load only on processor data-out
// - bound/relocation otherwise cleared only by master start
// - user flag, illegal latch cleared by master start
// - three sync flip-flops cleared by master clear
// - interrupt sync: set cycle flag level, clear sequence begin
// - trap sync: set address cycle, clear sequence end
// - restore jump sets executive sync via bits
// - user flag saved as miscellaneous bit five
// - executive sync falling at sequence end sets user
// - user addresses checked and relocated
// - inhibit both whenever user flag clear
// - fast memory never relocated
// - interrupt cycle addresses bypass relocation/protection
// - interrupt subroutine jump clears user flag
// - user dismiss/halt jumps and io become traps
// - jump and io commands only when untrapped
// - unimplemented opcode traps once trap sync set
// - trap level inhibits relocation, sets latch
// - latch extends inhibit; jump clears flag, latch
// - block io clears illegal latch once trap sync set
// - protection violation interrupts at sequence end
// - console insert sets latch, return clears it
//
// The register addresses and the Avalon-MM register port were decided locally.
`timescale 1ns/1ps
`default_nettype none

module emx_exec_ctrl
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire emx_pkg::emx_seq_type seq,
   input wire emx_pkg::emx_dec_type dec,
   output emx_pkg::emx_out_type cmd
);

   logic rst_meta_q;
   logic rst_sync_q;
   logic ack_q;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic soft_mstart_q;
   logic soft_mclear_q;
   logic soft_vack_q;
   logic master_start;
   logic master_clear;
   logic user_q;
   logic ill_op_q;
   logic pi_sync_q;
   logic trap_sync_q;
   logic ex_sync_q;
   logic viol_pend_q;
   logic viol_seen_q;
   logic chan_req_q;
   logic [15:0] trap_cnt_q;
   logic trap_level;
   logic user_trap;
   logic ex_sync_set;
   logic user_clr;
   logic wr_take;
   logic rd_take;

   // reset released through two flip-flops
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end
      else
      begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end

   // software can issue master start and clear as well as the console
   assign master_start = seq.master_start | soft_mstart_q;
   assign master_clear = seq.master_clear | soft_mclear_q;

   // bus: one wait cycle per access, answer on the second edge
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
   assign wr_take = avs_write & ack_q;
   assign rd_take = avs_read & ~ack_q;

   always_ff @(posedge mclk or negedge rst_sync_q)
   begin
      if (!rst_sync_q)
         ack_q <= 1'b0;
      else
         ack_q <= (avs_read | avs_write) & ~ack_q;
   end

   always_comb
   begin
      rdata_d = emx_pkg::RDATA_RST;
      unique case (avs_address)
         emx_pkg::STATUS_OFS:
         begin
            rdata_d[emx_pkg::ST_USER_BIT] = user_q;
            rdata_d[emx_pkg::ST_ILLOP_BIT] = ill_op_q;
            rdata_d[emx_pkg::ST_PISYNC_BIT] = pi_sync_q;
            rdata_d[emx_pkg::ST_TRAPSYNC_BIT] = trap_sync_q;
            rdata_d[emx_pkg::ST_EXSYNC_BIT] = ex_sync_q;
            rdata_d[emx_pkg::ST_VIOL_BIT] = viol_pend_q;
            rdata_d[emx_pkg::ST_VIOLSEEN_BIT] = viol_seen_q;
         end
         emx_pkg::TRAPCNT_OFS:
            rdata_d[15:0] = trap_cnt_q;
         default:
            rdata_d = emx_pkg::RDATA_RST;
      endcase
   end

   // read data captured while waitrequest is high, stands at the taking edge
   always_ff @(posedge mclk or negedge rst_sync_q)
   begin
      if (!rst_sync_q)
         rdata_q <= emx_pkg::RDATA_RST;
      else if (rd_take)
         rdata_q <= rdata_d;
   end

   assign avs_readdata = rdata_q;

   // control writes become single-cycle pulses
   always_ff @(posedge mclk or negedge rst_sync_q)
   begin
      if (!rst_sync_q)
      begin
         soft_mstart_q <= 1'b0;
         soft_mclear_q <= 1'b0;
         soft_vack_q <= 1'b0;
      end
      else
      begin
         soft_mstart_q <= wr_take && avs_address == emx_pkg::CTRL_OFS
                          && avs_writedata[emx_pkg::CTRL_MSTART_BIT];
         soft_mclear_q <= wr_take && avs_address == emx_pkg::CTRL_OFS
                          && avs_writedata[emx_pkg::CTRL_MCLEAR_BIT];
         soft_vack_q <= wr_take && avs_address == emx_pkg::CTRL_OFS
                        && avs_writedata[emx_pkg::CTRL_VIOL_ACK_BIT];
      end
   end

   // bound and relocation pulses; the registers live in the address logic
   assign cmd.bound_clr = (seq.data_out_clr & seq.processor_device_select)
                          | master_start;
   assign cmd.reloc_clr = (seq.data_out_clr & seq.processor_device_select)
                          | master_start;
   assign cmd.bound_set = seq.data_out_set & seq.processor_device_select;
   assign cmd.reloc_set = seq.data_out_set & seq.processor_device_select;

   // interrupt sync: level set dominates master clear while cycle flag is 1
   always_ff @(posedge mclk or negedge rst_sync_q)
   begin
      if (!rst_sync_q)
         pi_sync_q <= 1'b0;
      else if (seq.interrupt_cycle_flag)
         pi_sync_q <= 1'b1;
      else if (master_clear || seq.main_seq_begin)
         pi_sync_q <= 1'b0;
   end

   // trap sync keeps a cleared holder from looking like a trap opcode
   always_ff @(posedge mclk or negedge rst_sync_q)
   begin
      if (!rst_sync_q)
         trap_sync_q <= 1'b0;
      else if (seq.address_cycle_start)
         trap_sync_q <= 1'b1;
      else if (master_clear || seq.main_seq_end)
         trap_sync_q <= 1'b0;
   end

   // user-mode trap conditions; block io in an interrupt cycle is exempt
   assign user_trap = user_q & ((dec.restore_jump & (dec.jump_dismiss | dec.jump_halt))
                      | (dec.io_transfer_instr & ~(dec.block_io & pi_sync_q)));
   assign trap_level = trap_sync_q & (dec.unimplemented_op_trap | user_trap);
   assign cmd.trap_command_level = trap_level;

   // decoder commands pass only when not replaced by a trap
   assign cmd.restore_jump_cmd = dec.restore_jump & ~trap_level;
   assign cmd.io_cmd = dec.io_transfer_instr & ~trap_level;

   // executive sync from a restore jump that is actually executed
   // held off at sequence end so the sync falls there and hands over to user, unless master clear drops it first
   assign ex_sync_set = cmd.restore_jump_cmd & trap_sync_q & ~seq.main_seq_end
                        & (dec.instr_bit12 | (dec.instr_bit11 & dec.saved_user_bit));

   always_ff @(posedge mclk or negedge rst_sync_q)
   begin
      if (!rst_sync_q)
         ex_sync_q <= 1'b0;
      else if (ex_sync_set)
         ex_sync_q <= 1'b1;
      else if (master_clear || seq.main_seq_end)
         ex_sync_q <= 1'b0;
   end

   // subroutine jump leaving user mode: trap entry or interrupt entry
   assign user_clr = seq.execute_time_seven & dec.subroutine_jump_save
                     & (ill_op_q | pi_sync_q);

   // user flag survives master clear; restore jump never writes it directly
   always_ff @(posedge mclk or negedge rst_sync_q)
   begin
      if (!rst_sync_q)
         user_q <= 1'b0;
      else if (master_start)
         user_q <= 1'b0;
      else if (ex_sync_q && seq.main_seq_end && !master_clear)
         user_q <= 1'b1;
      else if (user_clr)
         user_q <= 1'b0;
   end

   assign cmd.user_mode_flag = user_q;
   // sampled by the buffer at the miscellaneous-bit store, after the jump's save
   assign cmd.misc_bits_user = user_q;

   // illegal-operation latch; a setting event wins over a same-cycle clear other than master start
   always_ff @(posedge mclk or negedge rst_sync_q)
   begin
      if (!rst_sync_q)
         ill_op_q <= 1'b0;
      else if (master_start)
         ill_op_q <= 1'b0;
      else if (trap_level && seq.execute_time_one)
         ill_op_q <= 1'b1;
      else if (seq.store_time_seven && seq.console_insert)
         ill_op_q <= 1'b1;
      else if (seq.execute_time_eight && dec.subroutine_jump_save && ill_op_q)
         ill_op_q <= 1'b0;
      else if (dec.block_io && trap_sync_q)
         ill_op_q <= 1'b0;
      else if (seq.rw_return && seq.console_insert)
         ill_op_q <= 1'b0;
   end

   // relocation and protection inhibits for the memory address logic
   assign cmd.reloc_inhibit = ~user_q
                              | dec.fast_mem_addr
                              | pi_sync_q | dec.channel_addr
                              | trap_level
                              | ill_op_q;
   assign cmd.protect_inhibit = ~user_q
                                | dec.fast_mem_addr
                                | pi_sync_q;

   // a violation is only meaningful while checking is live
   always_ff @(posedge mclk or negedge rst_sync_q)
   begin
      if (!rst_sync_q)
         viol_pend_q <= 1'b0;
      else if (dec.protect_violation && !cmd.protect_inhibit)
         viol_pend_q <= 1'b1;
      else if (seq.main_seq_end || master_start)
         viol_pend_q <= 1'b0;
   end

   // interrupt request raised after the current main sequence finishes
   always_ff @(posedge mclk or negedge rst_sync_q)
   begin
      if (!rst_sync_q)
         chan_req_q <= 1'b0;
      else
         chan_req_q <= viol_pend_q & seq.main_seq_end;
   end

   assign cmd.processor_channel_req = chan_req_q;

   // sticky record for software; a new violation wins over acknowledge
   always_ff @(posedge mclk or negedge rst_sync_q)
   begin
      if (!rst_sync_q)
         viol_seen_q <= 1'b0;
      else if (chan_req_q)
         viol_seen_q <= 1'b1;
      else if (soft_vack_q || master_start)
         viol_seen_q <= 1'b0;
   end

   // count of trap entries, saturating so it never wraps to look idle
   always_ff @(posedge mclk or negedge rst_sync_q)
   begin
      if (!rst_sync_q)
         trap_cnt_q <= emx_pkg::TRAPCNT_RST;
      else if (master_start)
         trap_cnt_q <= emx_pkg::TRAPCNT_RST;
      else if (trap_level && seq.execute_time_one && trap_cnt_q != 16'hFFFF)
         trap_cnt_q <= trap_cnt_q + emx_pkg::TRAPCNT_ONE;
   end

endmodule

`default_nettype wire

// [hdl/emx_pkg.sv]
// package for the user-mode executive control block
package emx_pkg;

   // register byte offsets
   localparam logic [3:0] CTRL_OFS = 4'h0;
   localparam logic [3:0] STATUS_OFS = 4'h4;
   localparam logic [3:0] TRAPCNT_OFS = 4'h8;

   // control register fields (write-one pulses)
   localparam int CTRL_MSTART_BIT = 0;
   localparam int CTRL_MCLEAR_BIT = 1;
   localparam int CTRL_VIOL_ACK_BIT = 2;

   // status register fields
   localparam int ST_USER_BIT = 0;
   localparam int ST_ILLOP_BIT = 1;
   localparam int ST_PISYNC_BIT = 2;
   localparam int ST_TRAPSYNC_BIT = 3;
   localparam int ST_EXSYNC_BIT = 4;
   localparam int ST_VIOL_BIT = 5;
   localparam int ST_VIOLSEEN_BIT = 6;

   // reset values and the trap counter increment
   localparam logic [31:0] RDATA_RST = 32'h0000_0000;
   localparam logic [15:0] TRAPCNT_RST = 16'h0000;
   localparam logic [15:0] TRAPCNT_ONE = 16'h0001;

   // position of the user flag among the saved miscellaneous bits
   localparam int SAVED_USER_POS = 5;

   // main-sequence timing pulses and levels from the processor
   typedef struct packed {
      logic master_start;
      logic master_clear;
      logic interrupt_cycle_flag;
      logic main_seq_begin;
      logic main_seq_end;
      logic address_cycle_start;
      logic execute_time_one;
      logic execute_time_seven;
      logic execute_time_eight;
      logic store_time_seven;
      logic console_insert;
      logic rw_return;
      logic data_out_clr;
      logic data_out_set;
      logic processor_device_select;
   } emx_seq_type;

   // instruction decoder outputs and address qualifiers
   typedef struct packed {
      logic restore_jump;
      logic io_transfer_instr;
      logic block_io;
      logic unimplemented_op_trap;
      logic subroutine_jump_save;
      logic jump_dismiss;
      logic jump_halt;
      logic instr_bit11;
      logic instr_bit12;
      logic saved_user_bit;
      logic fast_mem_addr;
      logic channel_addr;
      logic protect_violation;
   } emx_dec_type;

   // commands to the processor and memory address logic
   typedef struct packed {
      logic bound_clr;
      logic bound_set;
      logic reloc_clr;
      logic reloc_set;
      logic reloc_inhibit;
      logic protect_inhibit;
      logic restore_jump_cmd;
      logic io_cmd;
      logic trap_command_level;
      logic user_mode_flag;
      logic misc_bits_user;
      logic processor_channel_req;
   } emx_out_type;

endpackage

// [tb/emx_exec_ctrl_props.sv]
// concurrent checks on the executive control ports
`timescale 1ns/1ps
`default_nettype none
module emx_exec_ctrl_props
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire emx_pkg::emx_seq_type seq,
   input wire emx_pkg::emx_dec_type dec,
   input wire emx_pkg::emx_out_type cmd
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!nrst);
   sequence one_wait;
      avs_waitrequest ##1 !avs_waitrequest;
   endsequence
   chk_bus_one_wait: assert property ($rose(avs_read || avs_write) |-> one_wait)
      else $error("bus answer not after one wait");
   chk_load_gate: assert property (
      cmd.bound_set == (seq.data_out_set && seq.processor_device_select)
      && cmd.reloc_clr == (seq.data_out_clr && seq.processor_device_select
      || seq.master_start || $past(avs_write && !avs_waitrequest
      && avs_address == emx_pkg::CTRL_OFS && avs_writedata[emx_pkg::CTRL_MSTART_BIT])))
      else $error("load pulse not gated by device select");
   chk_user_inhibit: assert property (
      !cmd.user_mode_flag |-> cmd.reloc_inhibit && cmd.protect_inhibit)
      else $error("inhibit missing in executive mode");
   chk_fast_mem: assert property (dec.fast_mem_addr |-> cmd.reloc_inhibit)
      else $error("fast memory relocated");
   chk_pi_channel: assert property (
      seq.interrupt_cycle_flag && dec.channel_addr |-> cmd.reloc_inhibit)
      else $error("channel address relocated");
   chk_trap_blocks: assert property (
      cmd.trap_command_level |-> cmd.reloc_inhibit && !cmd.restore_jump_cmd && !cmd.io_cmd)
      else $error("trap level with command or relocation");
   chk_user_rise: assert property (
      $rose(cmd.user_mode_flag) |-> $past(seq.main_seq_end))
      else $error("user flag set away from sequence end");
   chk_user_fall: assert property (
      $fell(cmd.user_mode_flag)
      |-> $past(seq.master_start || seq.execute_time_seven && dec.subroutine_jump_save))
      else $error("user flag cleared without cause");
   chk_user_saved: assert property (cmd.misc_bits_user == cmd.user_mode_flag)
      else $error("saved user bit differs");
   chk_irq_at_end: assert property (
      cmd.processor_channel_req |-> $past(seq.main_seq_end))
      else $error("channel request not after sequence end");
endmodule
`default_nettype wire

// [tb/emx_seq_model.sv]
// main-sequence timing model of the processor side
`timescale 1ns/1ps
`default_nettype none
module emx_seq_model
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic go,
   input wire emx_pkg::emx_seq_type lvl,
   output emx_pkg::emx_seq_type seq,
   output logic [2:0] phase
);
   // one sequence at a time; a go during a run is lost
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
         phase <= 3'h0;
      else if (phase == 3'h6)
         phase <= 3'h0;
      else if (phase != 3'h0 || go)
         phase <= phase + 3'h1;
   end
   // case equality keeps the pulses low before reset lands
   always_comb
   begin
      seq = lvl;
      seq.main_seq_begin = phase === 3'h1;
      seq.address_cycle_start = phase === 3'h2;
      seq.execute_time_one = phase === 3'h3;
      seq.execute_time_seven = phase === 3'h4;
      seq.execute_time_eight = phase === 3'h5;
      seq.main_seq_end = phase === 3'h6;
   end
endmodule
`default_nettype wire

// [tb/emx_exec_ctrl_test.sv]
// self-checking bench for the user-mode executive control
`timescale 1ns/1ps
`default_nettype none
module emx_exec_ctrl_test;
   logic mclk = 1'h0;
   logic nrst = 1'h0;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'h0;
   logic avs_write = 1'h0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic go = 1'h0;
   logic [2:0] phase;
   logic [31:0] q;
   logic tr;
   logic [5:0] tbl [5];
   emx_pkg::emx_seq_type lvl = '0;
   emx_pkg::emx_seq_type seq;
   emx_pkg::emx_dec_type dec = '0;
   emx_pkg::emx_out_type cmd;
   int mismatches = 0;
   int n_tests = 0;
   int n_irq = 0;
   int r;
   always #2.5 mclk = ~mclk;
   always @(posedge mclk)
      if (cmd.processor_channel_req === 1'h1) n_irq <= n_irq + 1;
   emx_exec_ctrl DUT (.mclk(mclk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .seq(seq), .dec(dec), .cmd(cmd));
   emx_seq_model model (.mclk(mclk), .nrst(nrst), .go(go), .lvl(lvl), .seq(seq), .phase(phase));
   task chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e)
      begin
         mismatches++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= !w;
      avs_write <= w;
      @(posedge mclk);
      while (avs_waitrequest !== 1'h0 && n < 50)
      begin
         n++;
         @(posedge mclk);
      end
      chk(32'(n < 50), 32'h1);
      q = avs_readdata;
      avs_read <= 1'h0;
      avs_write <= 1'h0;
   endtask
   function logic [31:0] stv(input logic u, input logic i);
      return (32'(u) << emx_pkg::ST_USER_BIT) | (32'(i) << emx_pkg::ST_ILLOP_BIT);
   endfunction
   function logic exp_trap(input logic [5:0] t);
      return t[5] & (t[4] | t[3]) | t[2] & ~(t[1] & t[0]);
   endfunction
   task ust(input logic u, input logic i);
      bus(1'h0, emx_pkg::STATUS_OFS, 32'h0);
      chk(q & 32'h3, stv(u, i));
   endtask
   task pls(input emx_pkg::emx_seq_type m);
      @(posedge mclk);
      lvl <= lvl | m;
      @(posedge mclk);
      lvl <= lvl & ~m;
   endtask
   task start;
      @(posedge mclk);
      go <= 1'h1;
      @(posedge mclk);
      go <= 1'h0;
   endtask
   task ph(input logic [2:0] p);
      int n;
      n = 0;
      @(negedge mclk);
      while (phase !== p && n < 40)
      begin
         n++;
         @(negedge mclk);
      end
      chk(32'(n < 40), 32'h1);
   endtask
   task give_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial
   begin
      repeat (4000) @(posedge mclk);
      mismatches++;
      give_verdict;
   end
   initial
   begin
      r = $urandom(32'h82336054);
      tbl = '{6'h07, 6'h04, 6'h30, 6'h28, 6'h20};
      repeat (8) @(posedge mclk);
      nrst <= 1'h1;
      repeat (3) @(posedge mclk);
      bus(1'h0, emx_pkg::STATUS_OFS, 32'h0);
      chk(q, emx_pkg::RDATA_RST);
      chk(32'(cmd.reloc_inhibit & cmd.protect_inhibit), 32'h1);
      bus(1'h1, emx_pkg::STATUS_OFS, $urandom);
      bus(1'h0, 4'hC, 32'h0);
      chk(q, 32'h0);
      ust(1'h0, 1'h0);
      $display("test reset done");
      repeat (16)
      begin
         r = $urandom;
         @(posedge mclk);
         lvl <= '{data_out_set:r[0], data_out_clr:r[1], processor_device_select:r[2],
            default:1'h0};
         @(negedge mclk);
         chk(32'({cmd.bound_set, cmd.reloc_set, cmd.bound_clr, cmd.reloc_clr}),
            32'({{2{r[0] & r[2]}}, {2{r[1] & r[2]}}}));
      end
      lvl <= '0;
      dec <= '{unimplemented_op_trap:1'h1, default:1'h0};
      start;
      ph(3'h1);
      chk(32'(cmd.trap_command_level), 32'h0);
      ph(3'h3);
      chk(32'(cmd.trap_command_level & cmd.reloc_inhibit), 32'h1);
      ph(3'h0);
      ust(1'h0, 1'h1);
      dec <= '{subroutine_jump_save:1'h1, default:1'h0};
      start;
      ph(3'h0);
      ust(1'h0, 1'h0);
      $display("test executive trap done");
      dec <= '{restore_jump:1'h1, instr_bit12:1'h1, default:1'h0};
      start;
      ph(3'h5);
      chk(32'(cmd.user_mode_flag), 32'h0);
      ph(3'h0);
      dec <= '0;
      ust(1'h1, 1'h0);
      chk(q >> emx_pkg::ST_EXSYNC_BIT & 32'h1, 32'h0);
      chk(32'(cmd.misc_bits_user), 32'h1);
      chk(32'(cmd.reloc_inhibit | cmd.protect_inhibit), 32'h0);
      foreach (tbl[i])
      begin
         lvl.interrupt_cycle_flag <= tbl[i][0];
         dec <= '{restore_jump:tbl[i][5], jump_dismiss:tbl[i][4], jump_halt:tbl[i][3],
            io_transfer_instr:tbl[i][2], block_io:tbl[i][1], default:1'h0};
         tr = exp_trap(tbl[i]);
         start;
         ph(3'h3);
         chk(32'({cmd.trap_command_level, cmd.io_cmd, cmd.restore_jump_cmd}),
            32'({tr, tbl[i][2] & !tr, tbl[i][5] & !tr}));
         ph(3'h0);
      end
      lvl <= '0;
      dec <= '{subroutine_jump_save:1'h1, default:1'h0};
      ust(1'h1, 1'h1);
      chk(32'(cmd.reloc_inhibit), 32'h1);
      start;
      ph(3'h0);
      ust(1'h0, 1'h0);
      $display("test user traps done");
      dec <= '{restore_jump:1'h1, instr_bit11:1'h1, saved_user_bit:1'h1, default:1'h0};
      start;
      ph(3'h0);
      dec <= '0;
      ust(1'h1, 1'h0);
      start;
      ph(3'h3);
      dec.protect_violation <= 1'h1;
      @(negedge mclk);
      dec.protect_violation <= 1'h0;
      ph(3'h0);
      repeat (2) @(negedge mclk);
      chk(n_irq, 32'h1);
      lvl.interrupt_cycle_flag <= 1'h1;
      pls('{master_clear:1'h1, default:1'h0});
      ust(1'h1, 1'h0);
      chk(q >> emx_pkg::ST_PISYNC_BIT & 32'h1, 32'h1);
      dec <= '{subroutine_jump_save:1'h1, default:1'h0};
      start;
      ph(3'h0);
      dec <= '0;
      ust(1'h0, 1'h0);
      lvl <= '0;
      pls('{master_clear:1'h1, default:1'h0});
      ust(1'h0, 1'h0);
      chk(q >> emx_pkg::ST_PISYNC_BIT & 32'h1, 32'h0);
      $display("test user exit done");
      lvl.console_insert <= 1'h1;
      pls('{store_time_seven:1'h1, default:1'h0});
      ust(1'h0, 1'h1);
      pls('{rw_return:1'h1, default:1'h0});
      ust(1'h0, 1'h0);
      pls('{store_time_seven:1'h1, default:1'h0});
      ust(1'h0, 1'h1);
      lvl <= '0;
      dec <= '{block_io:1'h1, default:1'h0};
      start;
      ph(3'h0);
      dec <= '0;
      ust(1'h0, 1'h0);
      $display("test console done");
      bus(1'h0, emx_pkg::STATUS_OFS, 32'h0);
      chk(q >> emx_pkg::ST_VIOLSEEN_BIT & 32'h1, 32'h1);
      bus(1'h0, emx_pkg::TRAPCNT_OFS, 32'h0);
      chk(q, 32'h4);
      bus(1'h1, emx_pkg::CTRL_OFS, 32'h7);
      bus(1'h0, emx_pkg::TRAPCNT_OFS, 32'h0);
      chk(q, 32'h0);
      bus(1'h0, emx_pkg::STATUS_OFS, 32'h0);
      chk(q, emx_pkg::RDATA_RST);
      $display("test software start done");
      give_verdict;
   end
endmodule
bind emx_exec_ctrl emx_exec_ctrl_props chk (.mclk(mclk), .nrst(nrst), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .seq(seq), .dec(dec), .cmd(cmd));
`default_nettype wire
